//--- hw/eq_ctrl_pkg.sv
/*
 Constants for the equalizer channel control block: register offsets,
 field positions, reset values and pin default levels.
 Assumes a 32-bit APB master and a 125 MHz clock.
*/
// Summary of operation
// RULE_01: Each channel runs normally while its enable is high and stands by while it is low.
// RULE_02: An undriven channel enable reads as high, so the channel runs.
// RULE_03: With the source select high, boost comes from the three boost pins.
// RULE_04: With the source select low, boost comes from register bits.
// RULE_05: An undriven source select reads as high, choosing pin boost.
// RULE_06: Each signal-detect output is high while that channel sees a signal.
// RULE_07: Register access works only while chip select is high and is ignored otherwise.
// RULE_08: The bus data line is two-way, the bus clock an input, both idling high. The code never drives the data line; mgmt_bus_data_oe stays low.
// RULE_09: The boost pins set one strength for all channels; undriven msb is high, others low.
// RULE_10: The board may tie each signal-detect output back to the same channel's enable.
// RULE_11: Register boost gives each channel its own field, applied after the write completes.
package eq_ctrl_pkg;
	localparam int NUM_CHAN = 4;
	localparam int BOOST_W = 3;
	localparam logic [31:0] BOOST_OFFSET = 32'h0000_0000;
	localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;
	localparam int BOOST_FIELD_STRIDE = 4;
	localparam logic [2:0] BOOST_RESET = 3'h4;
	localparam int STAT_ENABLE_POS = 0;
	localparam int STAT_DETECT_POS = 4;
	localparam int STAT_SOURCE_POS = 8;
	localparam int STAT_PIN_BOOST_POS = 9;
	localparam int STAT_MGMT_CLK_POS = 12;
	localparam int STAT_MGMT_DATA_POS = 13;
	localparam logic ENABLE_DEFAULT = 1'b1;
	localparam logic SOURCE_DEFAULT = 1'b1;
	localparam logic BOOST_MSB_DEFAULT = 1'b1;
	localparam logic BOOST_LOW_DEFAULT = 1'b0;
	localparam logic MGMT_IDLE_LEVEL = 1'b1;
	localparam logic DETECT_DEFAULT = 1'b0;
	localparam logic SELECT_DEFAULT = 1'b0;
endpackage

//--- hw/pin_sync.sv
/*
 Two-flop synchroniser for one strap pin with a default level applied
 when the pin is undriven, plus one output flop.
 Assumes the pin and its driven flag come from outside the clock domain.
*/
`timescale 1ns/1ps
module pin_sync #(
	parameter logic DEFAULT_LEVEL = 1'b0
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic pin,
	input wire logic pin_driven,
	output logic level
);
	logic [1:0] sync1;
	logic [1:0] sync2;
	logic next_level;

	// Undriven pin falls back to its pull level
	always_comb
	begin
		next_level = sync2[1] ? sync2[0] : DEFAULT_LEVEL;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sync1 <= {1'b1, DEFAULT_LEVEL};
			sync2 <= {1'b1, DEFAULT_LEVEL};
			level <= DEFAULT_LEVEL;
		end
		else
		begin
			sync1 <= {pin_driven, pin};
			sync2 <= sync1;
			level <= next_level;
		end
	end
endmodule

//--- hw/equalizer_channel_control.sv
/*
 Digital control of a four-channel line equalizer: channel enables,
 boost source selection, per-channel boost, signal detect and an APB
 register bank gated by chip select.
 Assumes all pins are asynchronous and pulls are modelled by driven flags.
*/
`timescale 1ns/1ps
module equalizer_channel_control (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic chan0_enable,
	input wire logic chan1_enable,
	input wire logic chan2_enable,
	input wire logic chan3_enable,
	input wire logic [3:0] enable_driven,
	input wire logic boost_source_select,
	input wire logic boost_source_select_driven,
	input wire logic boost_pin_msb,
	input wire logic boost_pin_mid,
	input wire logic boost_pin_lsb,
	input wire logic [2:0] boost_pin_driven,
	input wire logic chip_select,
	input wire logic mgmt_bus_clock,
	input wire logic mgmt_bus_clock_driven,
	input wire logic mgmt_bus_data_in,
	input wire logic mgmt_bus_data_driven,
	input wire logic [3:0] signal_present,
	output logic [3:0] chan_normal,
	output logic [2:0] chan0_boost,
	output logic [2:0] chan1_boost,
	output logic [2:0] chan2_boost,
	output logic [2:0] chan3_boost,
	output logic chan0_signal_detect,
	output logic chan1_signal_detect,
	output logic chan2_signal_detect,
	output logic chan3_signal_detect,
	output logic mgmt_bus_data_out,
	output logic mgmt_bus_data_oe,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	localparam int N = eq_ctrl_pkg::NUM_CHAN;
	localparam int W = eq_ctrl_pkg::BOOST_W;

	logic [3:0] enable_pin;
	logic [3:0] enable_level;
	logic [3:0] detect_level;
	logic source_level;
	logic [2:0] pin_boost;
	logic select_level;
	logic mgmt_clk_level;
	logic mgmt_data_level;

	logic [W-1:0] boost_reg [N];
	logic [W-1:0] next_boost_reg [N];
	logic [W-1:0] next_chan_boost [N];
	logic [W-1:0] chan_boost [N];
	logic [3:0] next_chan_normal;
	logic [3:0] chan_detect;
	logic [3:0] next_chan_detect;
	logic next_mgmt_data_out;
	logic next_mgmt_data_oe;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic [31:0] boost_word;
	logic [31:0] status_word;
	logic hit_boost;
	logic hit_status;
	logic access;

	assign enable_pin = {chan3_enable, chan2_enable, chan1_enable, chan0_enable};

	// Channel enables, pulled high when undriven, and signal-detect inputs
	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : gen_chan
			pin_sync #(.DEFAULT_LEVEL(eq_ctrl_pkg::ENABLE_DEFAULT)) u_enable (
				.clk(clk),
				.rst_b(rst_b),
				.pin(enable_pin[g]),
				.pin_driven(enable_driven[g]), // see RULE_02
				.level(enable_level[g])
			);
			pin_sync #(.DEFAULT_LEVEL(eq_ctrl_pkg::DETECT_DEFAULT)) u_detect (
				.clk(clk),
				.rst_b(rst_b),
				.pin(signal_present[g]),
				.pin_driven(1'b1),
				.level(detect_level[g])
			);
		end
	endgenerate

	pin_sync #(.DEFAULT_LEVEL(eq_ctrl_pkg::SOURCE_DEFAULT)) u_source (
		.clk(clk),
		.rst_b(rst_b),
		.pin(boost_source_select),
		.pin_driven(boost_source_select_driven), // see RULE_05
		.level(source_level)
	);
	pin_sync #(.DEFAULT_LEVEL(eq_ctrl_pkg::BOOST_MSB_DEFAULT)) u_boost_msb (
		.clk(clk),
		.rst_b(rst_b),
		.pin(boost_pin_msb),
		.pin_driven(boost_pin_driven[2]), // see RULE_09
		.level(pin_boost[2])
	);
	pin_sync #(.DEFAULT_LEVEL(eq_ctrl_pkg::BOOST_LOW_DEFAULT)) u_boost_mid (
		.clk(clk),
		.rst_b(rst_b),
		.pin(boost_pin_mid),
		.pin_driven(boost_pin_driven[1]), // see RULE_09
		.level(pin_boost[1])
	);
	pin_sync #(.DEFAULT_LEVEL(eq_ctrl_pkg::BOOST_LOW_DEFAULT)) u_boost_lsb (
		.clk(clk),
		.rst_b(rst_b),
		.pin(boost_pin_lsb),
		.pin_driven(boost_pin_driven[0]), // see RULE_09
		.level(pin_boost[0])
	);
	pin_sync #(.DEFAULT_LEVEL(eq_ctrl_pkg::SELECT_DEFAULT)) u_select (
		.clk(clk),
		.rst_b(rst_b),
		.pin(chip_select),
		.pin_driven(1'b1),
		.level(select_level)
	);
	pin_sync #(.DEFAULT_LEVEL(eq_ctrl_pkg::MGMT_IDLE_LEVEL)) u_mgmt_clk (
		.clk(clk),
		.rst_b(rst_b),
		.pin(mgmt_bus_clock),
		.pin_driven(mgmt_bus_clock_driven), // see RULE_08
		.level(mgmt_clk_level)
	);
	pin_sync #(.DEFAULT_LEVEL(eq_ctrl_pkg::MGMT_IDLE_LEVEL)) u_mgmt_data (
		.clk(clk),
		.rst_b(rst_b),
		.pin(mgmt_bus_data_in),
		.pin_driven(mgmt_bus_data_driven), // see RULE_08
		.level(mgmt_data_level)
	);

	// Register words as read back
	always_comb
	begin
		boost_word = 32'h0000_0000;
		for (int i = 0; i < N; i++)
		begin
			boost_word[i*eq_ctrl_pkg::BOOST_FIELD_STRIDE +: W] = boost_reg[i];
		end
		status_word = 32'h0000_0000;
		status_word[eq_ctrl_pkg::STAT_ENABLE_POS +: N] = enable_level;
		status_word[eq_ctrl_pkg::STAT_DETECT_POS +: N] = detect_level;
		status_word[eq_ctrl_pkg::STAT_SOURCE_POS] = source_level;
		status_word[eq_ctrl_pkg::STAT_PIN_BOOST_POS +: W] = pin_boost;
		status_word[eq_ctrl_pkg::STAT_MGMT_CLK_POS] = mgmt_clk_level;
		status_word[eq_ctrl_pkg::STAT_MGMT_DATA_POS] = mgmt_data_level;
	end

	// APB slave with one wait state
	always_comb
	begin
		hit_boost = (paddr == eq_ctrl_pkg::BOOST_OFFSET);
		hit_status = (paddr == eq_ctrl_pkg::STATUS_OFFSET);
		access = psel && penable && pready;
		next_pready = psel && penable && !pready;
		next_prdata = 32'h0000_0000;
		next_pslverr = 1'b0;
		if (next_pready)
		begin
			if (!select_level || !(hit_boost || hit_status))
			begin
				next_pslverr = 1'b1; // see RULE_07
			end
			else if (!pwrite)
			begin
				next_prdata = hit_boost ? boost_word : status_word;
			end
		end
		for (int i = 0; i < N; i++)
		begin
			next_boost_reg[i] = boost_reg[i];
		end
		// Write lands only when selected and mapped
		if (access && pwrite && !pslverr && hit_boost)
		begin
			for (int i = 0; i < N; i++)
			begin
				if (pstrb[(i*eq_ctrl_pkg::BOOST_FIELD_STRIDE) / 8])
				begin
					next_boost_reg[i] = pwdata[i*eq_ctrl_pkg::BOOST_FIELD_STRIDE +: W];
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			for (int i = 0; i < N; i++)
			begin
				boost_reg[i] <= eq_ctrl_pkg::BOOST_RESET;
			end
		end
		else
		begin
			pready <= next_pready;
			pslverr <= next_pslverr;
			prdata <= next_prdata;
			for (int i = 0; i < N; i++)
			begin
				boost_reg[i] <= next_boost_reg[i];
			end
		end
	end

	// Channel mode, boost choice and detect
	always_comb
	begin
		next_chan_normal = enable_level; // see RULE_01
		next_chan_detect = detect_level; // see RULE_06
		// Data line never driven, so it rests on its pull-up
		next_mgmt_data_out = eq_ctrl_pkg::MGMT_IDLE_LEVEL;
		next_mgmt_data_oe = 1'b0; // see RULE_08
		for (int i = 0; i < N; i++)
		begin
			if (source_level)
			begin
				next_chan_boost[i] = pin_boost; // see RULE_03
			end
			else
			begin
				next_chan_boost[i] = boost_reg[i]; // see RULE_04, see RULE_11
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			chan_normal <= {N{eq_ctrl_pkg::ENABLE_DEFAULT}};
			chan_detect <= 4'h0;
			mgmt_bus_data_out <= eq_ctrl_pkg::MGMT_IDLE_LEVEL;
			mgmt_bus_data_oe <= 1'b0;
			for (int i = 0; i < N; i++)
			begin
				chan_boost[i] <= eq_ctrl_pkg::BOOST_RESET;
			end
		end
		else
		begin
			chan_normal <= next_chan_normal;
			chan_detect <= next_chan_detect;
			mgmt_bus_data_out <= next_mgmt_data_out;
			mgmt_bus_data_oe <= next_mgmt_data_oe;
			for (int i = 0; i < N; i++)
			begin
				chan_boost[i] <= next_chan_boost[i];
			end
		end
	end

	assign chan0_boost = chan_boost[0];
	assign chan1_boost = chan_boost[1];
	assign chan2_boost = chan_boost[2];
	assign chan3_boost = chan_boost[3];
	assign chan0_signal_detect = chan_detect[0];
	assign chan1_signal_detect = chan_detect[1];
	assign chan2_signal_detect = chan_detect[2];
	assign chan3_signal_detect = chan_detect[3];
endmodule

//--- bench/eq_ctrl_sva.sv
/* Port checker for equalizer_channel_control.
 Assumes the four-edge pin latency and one APB wait state. */
`timescale 1ns/1ps
module eq_ctrl_sva (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic chan0_enable,
	input wire logic [3:0] enable_driven,
	input wire logic chip_select,
	input wire logic [3:0] signal_present,
	input wire logic [3:0] chan_normal,
	input wire logic chan0_signal_detect,
	input wire logic mgmt_bus_data_out,
	input wire logic mgmt_bus_data_oe,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	logic en0;
	assign en0 = chan0_enable | ~enable_driven[0];
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	enable_follow_a: assert property (
		$past(rst_b, 5) |-> chan_normal[0] == $past(en0, 4)) else $error("Mode lags enable");
	detect_follow_a: assert property (
		$past(rst_b, 5) |-> chan0_signal_detect == $past(signal_present[0], 4))
		else $error("Detect wrong");
	cs_block_a: assert property (
		pready && !$past(chip_select, 4) |-> pslverr && prdata == 0)
		else $error("Access while deselected");
	ready_answer_a: assert property (psel && penable && !pready |=> pready)
		else $error("No answer");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("Ready too long");
	ready_access_a: assert property (pready |-> psel && penable)
		else $error("Ready outside access");
	err_pair_a: assert property (pslverr |-> pready)
		else $error("Error without ready");
	data_idle_a: assert property (!mgmt_bus_data_oe && mgmt_bus_data_out)
		else $error("Data line driven");
endmodule
bind equalizer_channel_control eq_ctrl_sva eq_ctrl_sva_i (.*);

//--- bench/board_model.sv
/* Board straps and bus lines beside the equalizer.
 Assumes the bench sets levels and loop-back. */
`timescale 1ns/1ps
module board_model (
	input wire logic loop_back,
	input wire logic [3:0] enable_level,
	input wire logic [3:0] detect,
	input wire logic data_oe,
	input wire logic data_out,
	output logic [3:0] enable,
	output logic mgmt_clock,
	output logic data_line
);
	assign enable = loop_back ? detect : enable_level;
	assign mgmt_clock = 1'h1;
	assign data_line = data_oe ? data_out : 1'h1;
endmodule

//--- bench/equalizer_channel_control_tb_top.sv
/* Bench for equalizer_channel_control with a board model.
 Assumes the four-edge pin latency. */
`timescale 1ns/1ps
module equalizer_channel_control_tb_top;
	logic clk = 1'h0, rst_b = 1'h0, boost_source_select = 1'h0, boost_source_select_driven = 1'h0;
	logic chip_select = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, loop_back = 1'h0;
	logic boost_pin_msb = 1'h0, boost_pin_mid = 1'h1, boost_pin_lsb = 1'h1, er;
	logic mgmt_bus_clock, mgmt_bus_data_in;
	logic [3:0] enable_driven = 4'h0, signal_present = 4'h0, pstrb = 4'hf, en_lvl = 4'h0;
	logic [2:0] boost_pin_driven = 3'h0;
	logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, rd, d;
	wire chan0_enable, chan1_enable, chan2_enable, chan3_enable, pready, pslverr;
	wire chan0_signal_detect, chan1_signal_detect, chan2_signal_detect, chan3_signal_detect;
	wire [3:0] chan_normal;
	wire [2:0] chan0_boost, chan1_boost, chan2_boost, chan3_boost;
	wire mgmt_bus_data_out, mgmt_bus_data_oe;
	wire [31:0] prdata;
	wire [31:0] outs = {12'h000, chan_normal, chan3_signal_detect, chan2_signal_detect,
		chan1_signal_detect, chan0_signal_detect, chan3_boost, chan2_boost, chan1_boost, chan0_boost};
	int errors = 0, n_compared = 0, cycles = 0, eb [4] = '{4, 4, 4, 4}, w;
	always #4 clk = ~clk;
	equalizer_channel_control equalizer_channel_control_i (.*, .mgmt_bus_clock_driven(1'h0),
		.mgmt_bus_data_driven(1'h0));
	board_model board_model_i (.loop_back(loop_back), .enable_level(en_lvl),
		.detect(outs[15:12]), .data_oe(mgmt_bus_data_oe), .data_out(mgmt_bus_data_out),
		.enable({chan3_enable, chan2_enable, chan1_enable, chan0_enable}),
		.mgmt_clock(mgmt_bus_clock), .data_line(mgmt_bus_data_in));
	task automatic complete_run();
		$display("Compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			errors++;
			complete_run();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] model();
		logic [31:0] v;
		logic [2:0] p;
		p = {boost_pin_msb | ~boost_pin_driven[2], boost_pin_mid & boost_pin_driven[1],
			boost_pin_lsb & boost_pin_driven[0]};
		v = {12'h000, (loop_back ? signal_present : en_lvl) | ~enable_driven, signal_present, 12'h000};
		for (int i = 0; i < 4; i++)
			v[3 * i +: 3] = (boost_source_select | ~boost_source_select_driven) ? p : 3'(eb[i]);
		return v;
	endfunction
	task automatic settle();
		repeat (8) @(posedge clk);
		chk(outs, model());
		$display("Step done at %0t", $time);
	endtask
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] dat);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= dat;
		@(posedge clk);
		penable <= 1'h1;
		do
			@(posedge clk);
		while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	initial
	begin
		void'($urandom(32'hc764_a200));
		repeat (16) @(posedge clk);
		rst_b <= 1'h1;
		settle();
		for (int k = 0; k < 8; k++)
		begin
			{en_lvl, enable_driven, signal_present, boost_pin_msb, boost_pin_mid, boost_pin_lsb,
				boost_pin_driven, boost_source_select, boost_source_select_driven} <= 20'($urandom);
			settle();
		end
		boost_source_select <= 1'h0;
		boost_source_select_driven <= 1'h1;
		for (int k = 0; k < 4; k++)
		begin
			d = $urandom;
			pstrb <= {2'h0, 2'(k + 1)};
			apb(1'h1, 32'h0000_0000, d);
			for (int i = 0; i < 4; i++)
				if (((k + 1) >> (i / 2)) & 1)
					eb[i] = (d >> (4 * i)) & 7;
			w = 0;
			for (int i = 0; i < 4; i++)
				w |= eb[i] << (4 * i);
			apb(1'h0, 32'h0000_0000, 32'h0000_0000);
			chk(rd, 32'(w));
			settle();
		end
		chip_select <= 1'h0;
		pstrb <= 4'hf;
		settle();
		apb(1'h1, 32'h0000_0000, 32'h0000_0000);
		chk({31'h0000_0000, er}, 32'h0000_0001);
		chip_select <= 1'h1;
		settle();
		apb(1'h0, 32'h0000_0010, 32'h0000_0000);
		chk({rd[30:0], er}, 32'h0000_0001);
		apb(1'h0, 32'h0000_0004, 32'h0000_0000);
		d = model();
		d = {18'h0_0000, 2'h3, boost_pin_msb | ~boost_pin_driven[2],
			boost_pin_mid & boost_pin_driven[1], boost_pin_lsb & boost_pin_driven[0],
			boost_source_select | ~boost_source_select_driven, d[15:12], d[19:16]};
		chk(rd, d);
		loop_back <= 1'h1;
		boost_source_select <= 1'h1;
		signal_present <= 4'h6;
		repeat (8) @(posedge clk);
		settle();
		settle();
		complete_run();
	end
endmodule
